/* hw/gif_consts.svh */
// Register map, field layout and timing constants of the input glitch filter
// Summary of operation
// - Low filter register holds 2-bit lengths for inputs 0-15, input n at 2n+1:2n.
// - High filter register holds 2-bit lengths for inputs 16-31, input 16 lowest.
// - Length zero passes the input after the synchronizer only, no extra filtering.
// - Length one needs a new level held one low-power clock sample.
// - Length two needs a new level held three low-power clock samples.
// - Length three needs a new level held eight low-power clock samples.
// - Both filter registers read and write, and reset to all zeros.
`ifndef GIF_CONSTS_SVH
`define GIF_CONSTS_SVH

`define GIF_ADDR_W 16
`define GIF_OFS_FILT_LOW 16'h1508
`define GIF_OFS_FILT_HIGH 16'h150c
`define GIF_FILT_RESET 32'h0000_0000
`define GIF_READ_UNMAPPED 32'h0000_0000
`define GIF_FIELD_W 2
`define GIF_PINS_PER_REG 16
`define GIF_SAMPLES_1 4'h1
`define GIF_SAMPLES_3 4'h3
`define GIF_SAMPLES_8 4'h8
`define GIF_CNT_W 4
`define GIF_CNT_ZERO 4'h0
`define GIF_CNT_ONE 4'h1

`endif

/* hw/gif_pkg.sv */
// Types shared by the input glitch filter modules
package gif_pkg;

  // Filter length selection held in each 2-bit field
  typedef enum logic [1:0] {
    gif_len_bypass = 2'h0,
    gif_len_one = 2'h1,
    gif_len_three = 2'h2,
    gif_len_eight = 2'h3
  } gif_len_e;

endpackage : gif_pkg

/* hw/gif_sync3.sv */
// Three-stage synchronizer with second/third stage agreement
`timescale 1ns/1ps
`include "gif_consts.svh"
module gif_sync3
  import gif_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Asynchronous pins in, settled level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] nxt_sync;

  // A change counts only once stages two and three agree
  assign agree = ~(stage2_ff ^ stage3_ff);
  assign nxt_sync = (agree & stage3_ff) | (~agree & sync_ff);

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      stage2_ff <= meta_ff;
      stage3_ff <= stage2_ff;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule : gif_sync3

/* hw/gif_pin_filter.sv */
// One input's sample-count glitch filter
`timescale 1ns/1ps
`include "gif_consts.svh"
module gif_pin_filter
  import gif_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Low-power clock sample tick and length selection
  input wire logic sample_tick,
  input wire logic [1:0] len_sel,
  // Synchronized level in, filtered level out
  input wire logic sync_in,
  output logic filt_out
);

  logic filt_ff;
  logic [`GIF_CNT_W-1:0] cnt_ff;
  logic [`GIF_CNT_W-1:0] need;
  logic [`GIF_CNT_W-1:0] cnt_inc;
  logic [`GIF_CNT_W-1:0] nxt_cnt;
  logic nxt_filt;
  logic differ;
  logic reached;
  logic bypass;

  // Required count from the length field
  always_comb begin
    case (gif_len_e'(len_sel))
      gif_len_one: need = `GIF_SAMPLES_1;
      gif_len_three: need = `GIF_SAMPLES_3;
      gif_len_eight: need = `GIF_SAMPLES_8;
      default: need = `GIF_CNT_ZERO;
    endcase
  end

  assign bypass = (gif_len_e'(len_sel) == gif_len_bypass);
  assign differ = (sync_in != filt_ff);
  assign cnt_inc = cnt_ff + `GIF_CNT_ONE;
  assign reached = sample_tick && (cnt_inc >= need);

  // Counter restarts on any agreement, so a glitch shorter than the length is lost
  assign nxt_cnt = (!differ || bypass) ? `GIF_CNT_ZERO :
                   reached ? `GIF_CNT_ZERO :
                   sample_tick ? cnt_inc : cnt_ff;
  assign nxt_filt = bypass ? sync_in :
                    (differ && reached) ? sync_in : filt_ff;

  // Filter state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_ff <= `GIF_CNT_ZERO;
      filt_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      filt_ff <= nxt_filt;
    end
  end

  assign filt_out = filt_ff;

endmodule : gif_pin_filter

/* hw/gif_top.sv */
// Input glitch filter top: register port, synchronizers and per-pin filters
`timescale 1ns/1ps
`include "gif_consts.svh"
module gif_top
  import gif_pkg::*;
#(
  parameter int NUM_PINS = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [`GIF_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Low-power peripheral clock, used as an asynchronous sample source
  input wire logic low_power_peripheral_clock,
  // Port input pins and filtered levels
  input wire logic [NUM_PINS-1:0] port_input_pin,
  output logic [NUM_PINS-1:0] port_input_filtered
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] filt_low_ff;
  logic [31:0] filt_high_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic sel_low;
  logic sel_high;

  assign sel_low = (reg_addr == `GIF_OFS_FILT_LOW);
  assign sel_high = (reg_addr == `GIF_OFS_FILT_HIGH);
  // Unmapped addresses read as zero and ignore writes
  assign nxt_rdata = !reg_rd ? `GIF_READ_UNMAPPED :
                     sel_low ? filt_low_ff :
                     sel_high ? filt_high_ff : `GIF_READ_UNMAPPED;

  // Writes land in one cycle; reads answer the next cycle only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      filt_low_ff <= `GIF_FILT_RESET;
      filt_high_ff <= `GIF_FILT_RESET;
      rdata_ff <= `GIF_READ_UNMAPPED;
    end else begin
      if (reg_wr && sel_low) begin
        filt_low_ff <= reg_wdata;
      end
      if (reg_wr && sel_high) begin
        filt_high_ff <= reg_wdata;
      end
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Low-power clock sampling

  logic [NUM_PINS:0] sync_all;
  logic lp_prev_ff;
  logic sample_tick;

  // The slow clock goes through the same synchronizer as the pins
  gif_sync3 #(
    .WIDTH(NUM_PINS + 1)
  ) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({low_power_peripheral_clock, port_input_pin}),
    .sync_out(sync_all)
  );

  // One sample per rising edge of the low-power clock
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lp_prev_ff <= 1'b0;
    end else begin
      lp_prev_ff <= sync_all[NUM_PINS];
    end
  end

  assign sample_tick = sync_all[NUM_PINS] && !lp_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin filters

  logic [63:0] len_all;
  assign len_all = {filt_high_ff, filt_low_ff};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      gif_pin_filter u_filt (
        .core_clk(core_clk),
        .reset(reset),
        .sample_tick(sample_tick),
        .len_sel(len_all[`GIF_FIELD_W*gi +: `GIF_FIELD_W]),
        .sync_in(sync_all[gi]),
        .filt_out(port_input_filtered[gi])
      );
    end
  endgenerate

endmodule : gif_top

/* test/gif_chk.sv */
// Port assertions for the glitch filter
`timescale 1ns/1ps
module gif_chk #(
  parameter int NUM_PINS = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register read side
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pins and filtered levels
  input wire logic low_power_peripheral_clock,
  input wire logic [NUM_PINS-1:0] port_input_pin,
  input wire logic [NUM_PINS-1:0] port_input_filtered
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  // Reset clears outputs; read data only after a read
  rst_clear_a: assert property ($fell(reset) |-> port_input_filtered == '0)
    else $error("filtered levels not cleared");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  unmapped_a: assert property (reg_rd && reg_addr != 16'h1508 && reg_addr != 16'h150c
    |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  // Without a pin change or a sample, the filtered levels may not move
  quiet_a: assert property (($stable(port_input_pin) && $stable(low_power_peripheral_clock))
    [*8] |=> $stable(port_input_filtered))
    else $error("filtered level moved without cause");
  // Reset clears outputs at the edge after it is seen, even while it still stands
  rst_hold_a: assert property (disable iff (1'b0) $past(reset)
    |-> port_input_filtered == '0 && reg_rdata == 32'h0)
    else $error("outputs not cleared by reset");
  // Read data stand for one cycle only unless another read follows
  rdata_once_a: assert property (reg_rdata != 32'h0 |=> reg_rdata == 32'h0 || $past(reg_rd))
    else $error("read data held too long");
endmodule : gif_chk

bind gif_top gif_chk #(.NUM_PINS(NUM_PINS)) u_chk (.core_clk(core_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .low_power_peripheral_clock(low_power_peripheral_clock),
  .port_input_pin(port_input_pin), .port_input_filtered(port_input_filtered));

/* test/gif_pins.sv */
// Model of the external pins and the slow sample clock
`timescale 1ns/1ps
module gif_pins (
  // Pacing clock
  input wire logic core_clk,
  // Slow clock and pin levels
  output logic lp_clk,
  output logic [31:0] pins
);
  initial begin
    lp_clk = 1'b0;
    pins = 32'h0;
  end
  // One slow period; idles low between calls so no stray sample lands
  task automatic tick();
    repeat (6) @(posedge core_clk);
    lp_clk <= 1'b1;
    repeat (6) @(posedge core_clk);
    lp_clk <= 1'b0;
  endtask : tick
endmodule : gif_pins

/* test/tb_top.sv */
// Self-checking bench for the glitch filter
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic lp_clk;
  logic [31:0] pins;
  logic [31:0] filt;
  int error_cnt = 0;
  int compares = 0;
  // Rows: address, written, read back (0x1510 is unmapped)
  logic [15:0] ra [5] = '{16'h1508, 16'h150c, 16'h1510, 16'h1508, 16'h150c};
  logic [31:0] rw [5] = '{32'hffffffff, 32'ha5a5c3c3, 32'h1234, 32'h39, 32'h2};
  logic [31:0] re [5] = '{32'hffffffff, 32'ha5a5c3c3, 32'h0, 32'h39, 32'h2};
  always #20 core_clk = ~core_clk;
  gif_pins u_pins (.core_clk(core_clk), .lp_clk(lp_clk), .pins(pins));
  gif_top DUT (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_power_peripheral_clock(lp_clk),
    .port_input_pin(pins), .port_input_filtered(filt));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_access(input logic [15:0] a, input logic [31:0] d, input logic wr);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask : reg_access
  task automatic report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////
  // Pins 0..3 use lengths 1, 3, 8, bypass; pin 16 uses 3 from the high register
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    reg_access(16'h1508, 32'h0, 1'b0);
    check(reg_rdata, 32'h0);
    reg_access(16'h150c, 32'h0, 1'b0);
    check(reg_rdata, 32'h0);
    for (int i = 0; i < 5; i++) begin
      reg_access(ra[i], rw[i], 1'b1);
      reg_access(ra[i], 32'h0, 1'b0);
      check(reg_rdata, re[i]);
    end
    u_pins.pins <= 32'h1000f;
    repeat (10) @(posedge core_clk);
    #1 check(filt & 32'h1000f, 32'h8);
    for (int k = 1; k <= 8; k++) begin
      u_pins.tick();
      repeat (8) @(posedge core_clk);
      #1 check(filt & 32'h1000f, {15'h0, k >= 3, 13'h1, k >= 8, k >= 3, 1'b1});
    end
    // A level that returns before its count restarts the count
    for (int r = 0; r < 2; r++) begin
      u_pins.pins <= 32'h0;
      repeat (10) @(posedge core_clk);
      u_pins.tick();
      u_pins.tick();
      repeat (8) @(posedge core_clk);
      #1 check(filt & 32'h1000f, 32'h10006);
      u_pins.pins <= 32'h1000f;
      repeat (10) @(posedge core_clk);
    end
    u_pins.pins <= 32'h0;
    repeat (10) @(posedge core_clk);
    repeat (3) u_pins.tick();
    repeat (8) @(posedge core_clk);
    #1 check(filt & 32'h1000f, 32'h4);
    // Reset in mid-run must clear the filtered levels and both registers
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 check(filt, 32'h0);
    @(posedge core_clk);
    reset <= 1'b0;
    reg_access(16'h1508, 32'h0, 1'b0);
    check(reg_rdata, 32'h0);
    reg_access(16'h150c, 32'h0, 1'b0);
    check(reg_rdata, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
